// ===== hdl/pcg_gate_sel.sv
// Selection of the active port clock-enable set by power mode.
`timescale 1ns/1ps
module pcg_gate_sel
  import pcg_pkg::*;
#(
  parameter int NPORTS = PCG_NPORTS
)
(
  input  wire logic [NPORTS-1:0] run_set,
  input  wire logic [NPORTS-1:0] sleep_set,
  input  wire logic [NPORTS-1:0] deep_set,
  input  wire logic [NPORTS-1:0] present,
  input  wire logic              auto_clock_gating,
  input  wire pcg_mode_t         mode,
  output logic      [NPORTS-1:0] active_set
);

  // ==========================================================================
  // Selection
  wire logic [NPORTS-1:0] low_set;
  wire logic [NPORTS-1:0] pick;

  // Without auto gating the run set stays in force in every mode.
  assign low_set    = (mode == PCG_MODE_DEEP) ? deep_set : sleep_set;
  assign pick       = (auto_clock_gating && mode != PCG_MODE_RUN) ? low_set
                                                                  : run_set; // see [R5] [R6]
  // Enables for absent ports never reach a clock.
  assign active_set = pick & present; // see [R10]

endmodule : pcg_gate_sel

// ===== hdl/pcg_pkg.sv
// Package of constants for the port clock gating and soft reset block.
package pcg_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [11:0] PCG_OFF_SRST0   = 12'h040;
  localparam logic [11:0] PCG_OFF_SRST1   = 12'h044;
  localparam logic [11:0] PCG_OFF_RCFG    = 12'h060;
  localparam logic [11:0] PCG_OFF_RUNG2   = 12'h108;
  localparam logic [11:0] PCG_OFF_SLPG2   = 12'h118;
  localparam logic [11:0] PCG_OFF_DSLG2   = 12'h128;
  localparam logic [11:0] PCG_OFF_INTST   = 12'h150;
  localparam logic [11:0] PCG_OFF_INTMSK  = 12'h154;
  localparam logic [11:0] PCG_OFF_STATE   = 12'h158;

  // ==========================================================================
  // Field positions and reset values
  localparam int          PCG_ACG_BIT     = 11;
  localparam int          PCG_NPORTS      = 8;
  localparam logic [31:0] PCG_SRST0_BITS  = 32'h0100_0048;
  localparam logic [31:0] PCG_SRST1_BITS  = 32'h030f_5037;
  localparam logic [7:0]  PCG_GATE_RST    = 8'h00;
  localparam logic [31:0] PCG_WORD_RST    = 32'h0000_0000;
  localparam int          PCG_EV_FAULT    = 0;
  localparam int          PCG_EV_MODE     = 1;
  localparam int          PCG_NEV         = 2;

  // ==========================================================================
  // Power modes
  typedef enum logic [1:0]
  {
    PCG_MODE_RUN   = 2'b00,
    PCG_MODE_SLEEP = 2'b01,
    PCG_MODE_DEEP  = 2'b11
  } pcg_mode_t;

endpackage : pcg_pkg

// ===== hdl/pcg_top.sv
// Port clock gating, soft reset control, bus fault and interrupt logic.
//
// Summary of operation
// [R1] Enable bit one clocks port; zero stops it.
// [R2] Access to unclocked unit returns bus fault.
// [R3] All clock enables reset to zero.
// [R4] Software must enable ports it uses.
// [R5] Run, sleep, deep-sleep sets chosen by mode.
// [R6] Sleep sets used only with auto gating.
// [R7] Bits 0 to 7 gate ports A to H.
// [R8] Deep-sleep gating register at offset 0x128.
// [R9] Reserved bits read zero, ignore writes.
// [R10] Enable bits of absent units do nothing.
// [R11] Reset register writes masked by capabilities.
// [R12] Reset bit holds unit until cleared.
// [R13] First reset map: CAN 24, hibernate 6, watchdog 3.
`timescale 1ns/1ps
module pcg_top
  import pcg_pkg::*;
#(
  parameter int          NPORTS        = PCG_NPORTS,
  parameter logic [7:0]  PORTS_PRESENT = 8'hff,
  parameter logic [31:0] CAP_MASK_1    = PCG_SRST0_BITS,
  parameter logic [31:0] CAP_MASK_2    = PCG_SRST1_BITS
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [11:0]       reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic [1:0]        power_mode,
  input  wire logic [NPORTS-1:0] port_access,
  output logic      [NPORTS-1:0] port_clk_en,
  output logic                   bus_fault,
  output logic      [31:0]       unit_reset_0,
  output logic      [31:0]       unit_reset_1,
  output logic                   irq
);

  // ==========================================================================
  // Elaboration check
  if (NPORTS != 8) begin : g_bad_nports
    $error("pcg_top: NPORTS must be 8");
  end

  // ==========================================================================
  // Registers
  logic [NPORTS-1:0] run_gate_reg;
  logic [NPORTS-1:0] sleep_gate_reg;
  logic [NPORTS-1:0] deep_gate_reg;
  logic [31:0]       srst0_reg;
  logic [31:0]       srst1_reg;
  logic              acg_reg;
  logic [PCG_NEV-1:0] int_st_reg;
  logic [PCG_NEV-1:0] int_st_next;
  logic [PCG_NEV-1:0] int_msk_reg;
  logic [1:0]        mode_sync1_reg;
  logic [1:0]        mode_sync2_reg;
  logic [NPORTS-1:0] acc_sync1_reg;
  logic [NPORTS-1:0] acc_sync2_reg;
  pcg_mode_t         mode_prev_reg;

  // ==========================================================================
  // Synchronisers for the pins from outside this domain
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_sync1_reg <= 2'h0;
      mode_sync2_reg <= 2'h0;
      acc_sync1_reg  <= '0;
      acc_sync2_reg  <= '0;
    end
    else
    begin
      mode_sync1_reg <= power_mode;
      mode_sync2_reg <= mode_sync1_reg;
      acc_sync1_reg  <= port_access;
      acc_sync2_reg  <= acc_sync1_reg;
    end
  end

  // ==========================================================================
  // Decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic wr_srst0 = reg_wr && hit(reg_addr, PCG_OFF_SRST0);
  wire logic wr_srst1 = reg_wr && hit(reg_addr, PCG_OFF_SRST1);
  wire logic wr_rcfg  = reg_wr && hit(reg_addr, PCG_OFF_RCFG);
  wire logic wr_run   = reg_wr && hit(reg_addr, PCG_OFF_RUNG2);
  wire logic wr_slp   = reg_wr && hit(reg_addr, PCG_OFF_SLPG2);
  wire logic wr_dsl   = reg_wr && hit(reg_addr, PCG_OFF_DSLG2); // see [R8]
  wire logic wr_ist   = reg_wr && hit(reg_addr, PCG_OFF_INTST);
  wire logic wr_imsk  = reg_wr && hit(reg_addr, PCG_OFF_INTMSK);

  wire pcg_mode_t   mode_now = pcg_mode_t'(mode_sync2_reg);
  wire logic [NPORTS-1:0] active_set;
  wire logic [NPORTS-1:0] fault_hits = acc_sync2_reg & ~active_set; // see [R2]
  wire logic        fault_ev = |fault_hits;
  wire logic        mode_ev  = (mode_now != mode_prev_reg);

  pcg_gate_sel #(
    .NPORTS            (NPORTS)
  ) u_gate_sel (
    .run_set           (run_gate_reg),
    .sleep_set         (sleep_gate_reg),
    .deep_set          (deep_gate_reg),
    .present           (PORTS_PRESENT[NPORTS-1:0]),
    .auto_clock_gating (acg_reg),
    .mode              (mode_now),
    .active_set        (active_set)
  );

  // ==========================================================================
  // Register writes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      run_gate_reg   <= PCG_GATE_RST; // see [R3]
      sleep_gate_reg <= PCG_GATE_RST; // see [R3]
      deep_gate_reg  <= PCG_GATE_RST; // see [R3]
      acg_reg        <= 1'b0;
      srst0_reg      <= PCG_WORD_RST;
      srst1_reg      <= PCG_WORD_RST;
      int_msk_reg    <= '0;
    end
    else
    begin
      // Only bits 7:0 are stored, so bit n gates port n and the rest read zero.
      if (wr_run)  run_gate_reg   <= reg_wdata[NPORTS-1:0]; // see [R7] [R9]
      if (wr_slp)  sleep_gate_reg <= reg_wdata[NPORTS-1:0]; // see [R7]
      if (wr_dsl)  deep_gate_reg  <= reg_wdata[NPORTS-1:0]; // see [R7]
      if (wr_rcfg) acg_reg        <= reg_wdata[PCG_ACG_BIT];
      if (wr_srst0) srst0_reg <= reg_wdata & CAP_MASK_1 & PCG_SRST0_BITS; // see [R11] [R13]
      if (wr_srst1) srst1_reg <= reg_wdata & CAP_MASK_2 & PCG_SRST1_BITS; // see [R11]
      if (wr_imsk) int_msk_reg    <= reg_wdata[PCG_NEV-1:0];
    end
  end

  // A new event beats a write-one-to-clear in the same cycle.
  always_comb
  begin
    int_st_next = int_st_reg;
    if (wr_ist)
      int_st_next = int_st_next & ~reg_wdata[PCG_NEV-1:0];
    if (fault_ev)
      int_st_next[PCG_EV_FAULT] = 1'b1;
    if (mode_ev)
      int_st_next[PCG_EV_MODE] = 1'b1;
  end

  // ==========================================================================
  // Read mux
  wire logic [31:0] rd_mux =
    hit(reg_addr, PCG_OFF_SRST0)  ? srst0_reg :
    hit(reg_addr, PCG_OFF_SRST1)  ? srst1_reg :
    hit(reg_addr, PCG_OFF_RCFG)   ? {20'h0, acg_reg, 11'h0} :
    hit(reg_addr, PCG_OFF_RUNG2)  ? {24'h0, run_gate_reg} :
    hit(reg_addr, PCG_OFF_SLPG2)  ? {24'h0, sleep_gate_reg} :
    hit(reg_addr, PCG_OFF_DSLG2)  ? {24'h0, deep_gate_reg} :
    hit(reg_addr, PCG_OFF_INTST)  ? {30'h0, int_st_reg} :
    hit(reg_addr, PCG_OFF_INTMSK) ? {30'h0, int_msk_reg} :
    hit(reg_addr, PCG_OFF_STATE)  ? {22'h0, mode_sync2_reg, active_set} :
    32'h0; // see [R9]

  // ==========================================================================
  // Outputs and status
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata     <= 32'h0;
      int_st_reg    <= '0;
      mode_prev_reg <= PCG_MODE_RUN;
      port_clk_en   <= '0;
      bus_fault     <= 1'b0;
      unit_reset_0  <= 32'h0;
      unit_reset_1  <= 32'h0;
      irq           <= 1'b0;
    end
    else
    begin
      reg_rdata     <= reg_rd ? rd_mux : 32'h0;
      int_st_reg    <= int_st_next;
      mode_prev_reg <= mode_now;
      port_clk_en   <= active_set;       // see [R1] [R5]
      bus_fault     <= fault_ev;         // see [R2]
      unit_reset_0  <= srst0_reg;        // see [R12]
      unit_reset_1  <= srst1_reg;        // see [R12]
      irq           <= |(int_st_next & int_msk_reg);
    end
  end

  // ==========================================================================
  // Assertions
  property p_clk_follows_set;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> port_clk_en == $past(active_set);
  endproperty
  a_clk_follows_set: assert property (p_clk_follows_set) // see [R1]
    else $error("port clock enable does not follow active set");

  property p_fault;
    @(posedge clk_sys) disable iff (rst)
      (|(acc_sync2_reg & ~active_set)) |=> bus_fault;
  endproperty
  a_fault: assert property (p_fault) // see [R2]
    else $error("access to gated port gave no bus fault");

  property p_no_fault;
    @(posedge clk_sys) disable iff (rst)
      (acc_sync2_reg & ~active_set) == '0 |=> !bus_fault;
  endproperty
  a_no_fault: assert property (p_no_fault) // see [R2]
    else $error("bus fault without gated access");

  property p_reset_zero;
    @(posedge clk_sys) $fell(rst) |-> port_clk_en == '0 && run_gate_reg == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // see [R3]
    else $error("clock enables not zero after reset");

  property p_no_acg_run;
    @(posedge clk_sys) disable iff (rst)
      !acg_reg |-> active_set == (run_gate_reg & PORTS_PRESENT);
  endproperty
  a_no_acg_run: assert property (p_no_acg_run) // see [R6]
    else $error("sleep set applied without auto gating");

  property p_deep_sel;
    @(posedge clk_sys) disable iff (rst)
      acg_reg && mode_now == PCG_MODE_DEEP |-> active_set == (deep_gate_reg & PORTS_PRESENT);
  endproperty
  a_deep_sel: assert property (p_deep_sel) // see [R5] [R8]
    else $error("deep sleep set not applied");

  property p_rsv_zero;
    @(posedge clk_sys) disable iff (rst)
      reg_rd |=> reg_rdata[31:8] == 24'h0 || $past(reg_addr) == PCG_OFF_SRST0
                 || $past(reg_addr) == PCG_OFF_SRST1
                 || $past(reg_addr) == PCG_OFF_STATE;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // see [R9]
    else $error("reserved bits read non-zero");

  property p_srst_mask;
    @(posedge clk_sys) disable iff (rst)
      wr_srst0 |=> srst0_reg == ($past(reg_wdata) & CAP_MASK_1 & PCG_SRST0_BITS);
  endproperty
  a_srst_mask: assert property (p_srst_mask) // see [R11] [R13]
    else $error("reset register write not masked");

  property p_srst_hold;
    @(posedge clk_sys) disable iff (rst)
      !wr_srst1 |=> unit_reset_1 == $past(unit_reset_1) || $past(wr_srst1, 2);
  endproperty
  a_srst_hold: assert property (p_srst_hold) // see [R12]
    else $error("unit reset changed without write");

endmodule : pcg_top

// ===== verification/pcg_top_bench.sv
// Self-checking bench for the port clock gating and soft reset block.
`timescale 1ns/1ps
module pcg_top_bench;
  import pcg_pkg::*;

  // ==========================================================================
  // Stimulus signals and counters
  logic        clk_sys;
  logic        rst;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [1:0]  power_mode;
  logic [7:0]  port_access;
  logic [7:0]  port_clk_en;
  logic        bus_fault;
  logic [31:0] unit_reset_0;
  logic [31:0] unit_reset_1;
  logic        irq;
  int          n_fail;
  int          samples_checked;
  int          faults;

  // Port H is left absent so that its enable bit must stay without effect.
  pcg_top #(.PORTS_PRESENT(8'h7f)) dut (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .power_mode   (power_mode),
    .port_access  (port_access),
    .port_clk_en  (port_clk_en),
    .bus_fault    (bus_fault),
    .unit_reset_0 (unit_reset_0),
    .unit_reset_1 (unit_reset_1),
    .irq          (irq)
  );

  // ==========================================================================
  // Bus tasks and comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), exp, reg_rdata);
  endtask : rdc

  // The mode pins take three cycles to reach the enables, so five are allowed.
  task automatic mode_chk(input pcg_mode_t m, input logic [7:0] exp);
    @(posedge clk_sys);
    power_mode <= m;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("port_clk_en", {24'h0, exp}, {24'h0, port_clk_en});
  endtask : mode_chk

  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    power_mode = PCG_MODE_RUN;
    port_access = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(PCG_OFF_SRST0, 32'h0);
    rdc(PCG_OFF_SRST1, 32'h0);
    rdc(PCG_OFF_RUNG2, 32'h0);
    rdc(PCG_OFF_SLPG2, 32'h0);
    rdc(PCG_OFF_DSLG2, 32'h0);
    chk("port_clk_en", 32'h0, {24'h0, port_clk_en});
    // Every port is switched on by software, since none starts enabled.
    wr(PCG_OFF_RUNG2, 32'hffff_ffff);
    rdc(PCG_OFF_RUNG2, 32'h0000_00ff);
    wr(PCG_OFF_SLPG2, 32'hffff_ffff);
    rdc(PCG_OFF_SLPG2, 32'h0000_00ff);
    wr(PCG_OFF_DSLG2, 32'hffff_ffff);
    rdc(PCG_OFF_DSLG2, 32'h0000_00ff);
    mode_chk(PCG_MODE_RUN, 8'h7f);
    wr(PCG_OFF_SRST0, 32'hffff_ffff);
    rdc(PCG_OFF_SRST0, 32'h0100_0048);
    chk("unit_reset_0", 32'h0100_0048, unit_reset_0);
    wr(PCG_OFF_SRST1, 32'hffff_ffff);
    rdc(PCG_OFF_SRST1, 32'h030f_5037);
    chk("unit_reset_1", 32'h030f_5037, unit_reset_1);
    wr(PCG_OFF_SRST0, 32'h0000_0000);
    // The reset outputs follow the register one cycle later.
    @(posedge clk_sys);
    #1;
    chk("unit_reset_0", 32'h0, unit_reset_0);
    wr(12'h7fc, 32'hffff_ffff);
    rdc(12'h7fc, 32'h0);
    wr(PCG_OFF_RUNG2, 32'h0000_0001);
    wr(PCG_OFF_SLPG2, 32'h0000_0002);
    wr(PCG_OFF_DSLG2, 32'h0000_0004);
    mode_chk(PCG_MODE_SLEEP, 8'h01);
    mode_chk(PCG_MODE_DEEP, 8'h01);
    wr(PCG_OFF_RCFG, 32'h0000_0800);
    mode_chk(PCG_MODE_SLEEP, 8'h02);
    mode_chk(PCG_MODE_DEEP, 8'h04);
    rdc(PCG_OFF_STATE, 32'h0000_0304);
    mode_chk(PCG_MODE_RUN, 8'h01);
    // Earlier mode changes left events behind; clear them first.
    wr(PCG_OFF_INTST, 32'h0000_0003);
    @(posedge clk_sys);
    port_access <= 8'h01;
    repeat (4) @(posedge clk_sys);
    port_access <= 8'h00;
    repeat (4) @(posedge clk_sys);
    rdc(PCG_OFF_INTST, 32'h0);
    @(posedge clk_sys);
    port_access <= 8'h02;
    @(posedge clk_sys);
    port_access <= 8'h00;
    faults = 0;
    repeat (6)
    begin
      @(posedge clk_sys);
      #1;
      if (bus_fault === 1'b1)
        faults++;
    end
    chk("bus_fault_count", 32'd1, faults);
    rdc(PCG_OFF_INTST, 32'h0000_0001);
    chk("irq", 32'h0, {31'h0, irq});
    wr(PCG_OFF_INTMSK, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    wr(PCG_OFF_INTST, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    // A second reset in mid-run must bring every enable back to zero.
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("port_clk_en", 32'h0, {24'h0, port_clk_en});
    rdc(PCG_OFF_RUNG2, 32'h0);
    wrap_up();
  end

endmodule : pcg_top_bench
